// >>> host_bus_model.sv
// Host processor model on the parallel register bus of the low window block.
// Assumes one clock; requests are driven after a rising edge and held one cycle.
`timescale 1ns/1ns
module host_bus_model
   import opl_pkg::*;
(
   input wire logic sys_clk,
   output bus_req_s bus_req,
   input wire logic [7:0] bus_rdata
);
   // ----------------------------------------------------------------
   // Bus cycles
   // ----------------------------------------------------------------
   initial begin
      bus_req = '0;
   end

   // Callers keep addresses inside 0x10..0x7f
   task automatic write_reg(input logic [6:0] addr, input logic [7:0] data);
      @(posedge sys_clk);
      bus_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus_req <= '0;
   endtask : write_reg

   // Read data is registered, so it is taken once the taking edge has settled
   task automatic read_reg(input logic [6:0] addr, output logic [7:0] data);
      @(posedge sys_clk);
      bus_req <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus_req <= '0;
      #1;
      data = bus_rdata;
   endtask : read_reg
endmodule : host_bus_model

// >>> opl_pkg.sv
// Package for the output port latch and low register window decode.
// Assumes an 8-bit parallel register bus with a 7-bit address and one clock.
package opl_pkg;

   // ----------------------------------------------------------------
   // Register offsets on the 7-bit address
   // ----------------------------------------------------------------
   localparam logic [6:0] ADDR_WINDOW_LO = 7'h10;
   localparam logic [6:0] ADDR_WINDOW_HI = 7'h1f;
   localparam logic [6:0] ADDR_FILL_SET_A = 7'h10;
   localparam logic [6:0] ADDR_FREE_CLR_A = 7'h11;
   localparam logic [6:0] ADDR_STATUS_CMD_A = 7'h12;
   localparam logic [6:0] ADDR_CHGU_SEL0 = 7'h13;
   localparam logic [6:0] ADDR_CHGL_SEL1 = 7'h14;
   localparam logic [6:0] ADDR_LEVEL_A = 7'h15;
   localparam logic [6:0] ADDR_TMR0_HIGH = 7'h16;
   localparam logic [6:0] ADDR_TMR0_LOW = 7'h17;
   localparam logic [6:0] ADDR_SET_B = 7'h18;
   localparam logic [6:0] ADDR_CLR_B = 7'h19;
   localparam logic [6:0] ADDR_CMD_B = 7'h1a;
   localparam logic [6:0] ADDR_CHGU_SEL2 = 7'h1b;
   localparam logic [6:0] ADDR_CHGL_SEL3 = 7'h1c;
   localparam logic [6:0] ADDR_LEVEL_B = 7'h1d;
   localparam logic [6:0] ADDR_TMR1_HIGH = 7'h1e;
   localparam logic [6:0] ADDR_TMR1_LOW = 7'h1f;

   // ----------------------------------------------------------------
   // Reset values and field codes
   // ----------------------------------------------------------------
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [7:0] SELECT_RESET = 8'h00;
   localparam logic [7:0] PRESET_RESET = 8'h00;
   localparam logic [7:0] CMD_RESET = 8'h00;
   localparam logic [7:0] READ_NONE = 8'h00;
   localparam logic [1:0] FUNC_LATCH_OUT = 2'h1;
   localparam int FUNC_CODE_W = 2;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [6:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bus_req_s;

   typedef struct packed {
      logic [7:0] level;
      logic [7:0] oe;
   } pin_drive_s;

   typedef struct packed {
      logic [7:0] data;
      logic stb;
   } cmd_word_s;

endpackage : opl_pkg

// >>> output_port_latch_and_low_decode.sv
// Output latches for ports A and B and the decode of the 0x10..0x1f register window.
// Assumes an 8-bit register bus whose strobes are synchronous to sys_clk and
// whose read-only sources come from neighbouring blocks as plain inputs.
//
// Notes on behaviour
// - A latch-driven pin shows the inverse of its latch bit.
// - A pin follows its latch only while its select code is 01.
// - Two independent 8-bit latches; bit n drives pin n of its port.
// - Latch contents can never be read back.
// - Latches change only through bit-set and bit-clear writes.
// - 0x10 reads port A receive fill; write sets port A latch bits.
// - 0x11 reads port A transmit free level; write clears port A bits.
// - 0x12 reads enhanced status; write loads port A command extension.
// - Enhanced status at 0x12 is chip-wide, not per port.
// - 0x13/0x14 read port A change bytes; write select registers 0/1.
// - 0x15 reads port A pin levels; writes there do nothing.
// - 0x16/0x17 read timer 0 value; write timer 0 preset bytes.
// - 0x18/0x19 write set/clear of port B latch; no read.
// - 0x1a write loads port B command extension; no read.
// - 0x1b/0x1c read port B change bytes; write select registers 2/3.
// - 0x1d reads port B pin levels; writes there do nothing.
// - 0x1e/0x1f read timer 1 value; write timer 1 preset bytes.
// - Bit-set write: ones set latch bits, zeros leave them.
// - Bit-clear write: ones clear latch bits, zeros leave them.
// - Select registers reset to zero, so every pin starts as input.
`timescale 1ns/1ns
module output_port_latch_and_low_decode
   import opl_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire bus_req_s bus_req,
   output logic [7:0] bus_rdata,
   input wire logic [7:0] rx_fill_count_a,
   input wire logic [7:0] tx_free_count_a,
   input wire logic [7:0] enhanced_status_word,
   input wire logic [7:0] input_change_upper_a,
   input wire logic [7:0] input_change_lower_a,
   input wire logic [7:0] input_change_upper_b,
   input wire logic [7:0] input_change_lower_b,
   input wire logic [15:0] timer0_value,
   input wire logic [15:0] timer1_value,
   input wire logic [7:0] io_a_in,
   input wire logic [7:0] io_b_in,
   output pin_drive_s io_a_drive,
   output pin_drive_s io_b_drive,
   output logic [15:0] pin_function_select_a,
   output logic [15:0] pin_function_select_b,
   output logic [15:0] timer0_preset,
   output logic [15:0] timer1_preset,
   output cmd_word_s command_extension_a,
   output cmd_word_s command_extension_b
);

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   logic in_window;
   logic wr_set_a;
   logic wr_clr_a;
   logic wr_set_b;
   logic wr_clr_b;
   logic [7:0] output_latch_a;
   logic [7:0] output_latch_b;

   // Only the low window is decoded here; the rest of the map answers elsewhere
   assign in_window = (bus_req.addr >= ADDR_WINDOW_LO) && (bus_req.addr <= ADDR_WINDOW_HI);
   assign wr_set_a = bus_req.wr && (bus_req.addr == ADDR_FILL_SET_A);
   assign wr_clr_a = bus_req.wr && (bus_req.addr == ADDR_FREE_CLR_A);
   assign wr_set_b = bus_req.wr && (bus_req.addr == ADDR_SET_B);
   assign wr_clr_b = bus_req.wr && (bus_req.addr == ADDR_CLR_B);

   // ----------------------------------------------------------------
   // Output latches and pin drive
   // ----------------------------------------------------------------
   port_latch u_latch_a (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .set_stb(wr_set_a),
      .clr_stb(wr_clr_a),
      .mask(bus_req.wdata),
      .latch(output_latch_a)
   );

   port_latch u_latch_b (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .set_stb(wr_set_b),
      .clr_stb(wr_clr_b),
      .mask(bus_req.wdata),
      .latch(output_latch_b)
   );

   pin_driver u_pins_a (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .latch(output_latch_a),
      .select(pin_function_select_a),
      .pins(io_a_drive)
   );

   pin_driver u_pins_b (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .latch(output_latch_b),
      .select(pin_function_select_b),
      .pins(io_b_drive)
   );

   // ----------------------------------------------------------------
   // Pin function select registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         pin_function_select_a <= {SELECT_RESET, SELECT_RESET};
         pin_function_select_b <= {SELECT_RESET, SELECT_RESET};
      end else if (bus_req.wr) begin
         case (bus_req.addr)
            ADDR_CHGU_SEL0: begin
               pin_function_select_a[7:0] <= bus_req.wdata;
            end
            ADDR_CHGL_SEL1: begin
               pin_function_select_a[15:8] <= bus_req.wdata;
            end
            ADDR_CHGU_SEL2: begin
               pin_function_select_b[7:0] <= bus_req.wdata;
            end
            ADDR_CHGL_SEL3: begin
               pin_function_select_b[15:8] <= bus_req.wdata;
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Timer preset registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         timer0_preset <= {PRESET_RESET, PRESET_RESET};
         timer1_preset <= {PRESET_RESET, PRESET_RESET};
      end else if (bus_req.wr) begin
         case (bus_req.addr)
            ADDR_TMR0_HIGH: begin
               timer0_preset[15:8] <= bus_req.wdata;
            end
            ADDR_TMR0_LOW: begin
               timer0_preset[7:0] <= bus_req.wdata;
            end
            ADDR_TMR1_HIGH: begin
               timer1_preset[15:8] <= bus_req.wdata;
            end
            ADDR_TMR1_LOW: begin
               timer1_preset[7:0] <= bus_req.wdata;
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Command extension words
   // ----------------------------------------------------------------
   // The strobe marks each write so the command decoder acts once per write
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         command_extension_a <= '{data: CMD_RESET, stb: 1'b0};
         command_extension_b <= '{data: CMD_RESET, stb: 1'b0};
      end else begin
         command_extension_a.stb <= bus_req.wr && (bus_req.addr == ADDR_STATUS_CMD_A);
         command_extension_b.stb <= bus_req.wr && (bus_req.addr == ADDR_CMD_B);
         if (bus_req.wr && (bus_req.addr == ADDR_STATUS_CMD_A)) begin
            command_extension_a.data <= bus_req.wdata;
         end
         if (bus_req.wr && (bus_req.addr == ADDR_CMD_B)) begin
            command_extension_b.data <= bus_req.wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read decode
   // ----------------------------------------------------------------
   logic [7:0] next_rdata;

   // Latch bits have no case here at all, so no address can expose them
   always_comb begin
      next_rdata = READ_NONE;
      case (bus_req.addr)
         ADDR_FILL_SET_A: begin
            next_rdata = rx_fill_count_a;
         end
         ADDR_FREE_CLR_A: begin
            next_rdata = tx_free_count_a;
         end
         ADDR_STATUS_CMD_A: begin
            next_rdata = enhanced_status_word;
         end
         ADDR_CHGU_SEL0: begin
            next_rdata = input_change_upper_a;
         end
         ADDR_CHGL_SEL1: begin
            next_rdata = input_change_lower_a;
         end
         ADDR_LEVEL_A: begin
            next_rdata = io_a_in;
         end
         ADDR_TMR0_HIGH: begin
            next_rdata = timer0_value[15:8];
         end
         ADDR_TMR0_LOW: begin
            next_rdata = timer0_value[7:0];
         end
         ADDR_CHGU_SEL2: begin
            next_rdata = input_change_upper_b;
         end
         ADDR_CHGL_SEL3: begin
            next_rdata = input_change_lower_b;
         end
         ADDR_LEVEL_B: begin
            next_rdata = io_b_in;
         end
         ADDR_TMR1_HIGH: begin
            next_rdata = timer1_value[15:8];
         end
         ADDR_TMR1_LOW: begin
            next_rdata = timer1_value[7:0];
         end
         default: begin
            next_rdata = READ_NONE;
         end
      endcase
   end

   // Read data is held until the next read so slow hosts can sample late
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         bus_rdata <= READ_NONE;
      end else if (bus_req.rd) begin
         bus_rdata <= in_window ? next_rdata : READ_NONE;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking chk_cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);

   set_bits_a: assert property (wr_set_a |=>
      output_latch_a == ($past(output_latch_a) | $past(bus_req.wdata)))
      else $error("port A bit-set write gave wrong latch");

   clear_bits_b: assert property (wr_clr_b |=>
      output_latch_b == ($past(output_latch_b) & ~$past(bus_req.wdata)))
      else $error("port B bit-clear write gave wrong latch");

   latch_only_strobes_a: assert property (!(wr_set_a || wr_clr_a || wr_set_b || wr_clr_b)
      |=> $stable(output_latch_a) && $stable(output_latch_b))
      else $error("latch changed without a set or clear write");

   ports_independent_a: assert property ((wr_set_a || wr_clr_a) |=>
      $stable(output_latch_b))
      else $error("port A write disturbed port B latch");

   pin_inverse_a: assert property (wr_set_a ##1 1'b1 |=>
      (io_a_drive.level == ~$past(output_latch_a)))
      else $error("port A pins do not show inverse of latch");

   pin_enable_a: assert property (bus_req.wr && (bus_req.addr == ADDR_CHGU_SEL0)
      && (bus_req.wdata[1:0] == FUNC_LATCH_OUT) |=> ##1 io_a_drive.oe[0])
      else $error("pin A0 not driven under select code 01");

   pin_release_a: assert property (bus_req.wr && (bus_req.addr == ADDR_CHGU_SEL0)
      && (bus_req.wdata[1:0] != FUNC_LATCH_OUT) |=> ##1 !io_a_drive.oe[0])
      else $error("pin A0 driven under another select code");

   read_fill_a: assert property (bus_req.rd && (bus_req.addr == ADDR_FILL_SET_A)
      |=> bus_rdata == $past(rx_fill_count_a))
      else $error("fill level read returned wrong value");

   read_status_a: assert property (bus_req.rd && (bus_req.addr == ADDR_STATUS_CMD_A)
      |=> bus_rdata == $past(enhanced_status_word))
      else $error("status read returned wrong value");

   no_latch_read_a: assert property (bus_req.rd && ((bus_req.addr == ADDR_SET_B)
      || (bus_req.addr == ADDR_CLR_B) || (bus_req.addr == ADDR_CMD_B)) |=> bus_rdata == READ_NONE)
      else $error("write-only address returned data");

   timer_preset_a: assert property (bus_req.wr && (bus_req.addr == ADDR_TMR1_LOW)
      |=> timer1_preset[7:0] == $past(bus_req.wdata) && $stable(timer1_preset[15:8]))
      else $error("timer 1 low preset not loaded");

   cmd_strobe_a: assert property (bus_req.wr && (bus_req.addr == ADDR_CMD_B)
      |=> command_extension_b.stb && !command_extension_a.stb
      && command_extension_b.data == $past(bus_req.wdata))
      else $error("port B command extension write mishandled");

   ignored_write_a: assert property (bus_req.wr && (bus_req.addr == ADDR_LEVEL_A)
      |=> $stable(pin_function_select_a) && $stable(timer0_preset) && $stable(output_latch_a))
      else $error("write to read-only address changed state");

   reset_values_a: assert property ($rose(rst_b) |-> (output_latch_a == LATCH_RESET)
      && (pin_function_select_a == 16'h0000) && (pin_function_select_b == 16'h0000)
      && (io_a_drive.oe == 8'h00) && (io_b_drive.oe == 8'h00))
      else $error("registers not at reset values after reset");

endmodule : output_port_latch_and_low_decode

// >>> output_port_latch_and_low_decode_tb.sv
// Self-checking bench for the output latches and the low register window decode.
// Assumes the host model above and read sources driven straight from the bench.
`timescale 1ns/1ns
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin fails++; \
   $display("ERROR %0t got %h expected %h", $time, (got), (exp)); end end
module output_port_latch_and_low_decode_tb;
   import opl_pkg::*;
   logic sys_clk;
   logic rst_b;
   bus_req_s bus_req;
   logic [7:0] bus_rdata;
   logic [7:0] rx_fill_count_a, tx_free_count_a, enhanced_status_word;
   logic [7:0] input_change_upper_a, input_change_lower_a;
   logic [7:0] input_change_upper_b, input_change_lower_b;
   logic [15:0] timer0_value, timer1_value;
   logic [7:0] io_a_in, io_b_in;
   pin_drive_s io_a_drive, io_b_drive;
   logic [15:0] pin_function_select_a, pin_function_select_b;
   logic [15:0] timer0_preset, timer1_preset;
   cmd_word_s command_extension_a, command_extension_b;
   int fails = 0;
   int check_count = 0;
   logic [7:0] rd_val;
   logic [6:0] rd_addr;

   host_bus_model host_u (.sys_clk(sys_clk), .bus_req(bus_req), .bus_rdata(bus_rdata));

   output_port_latch_and_low_decode dut_u (
      .sys_clk(sys_clk), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata),
      .rx_fill_count_a(rx_fill_count_a), .tx_free_count_a(tx_free_count_a),
      .enhanced_status_word(enhanced_status_word),
      .input_change_upper_a(input_change_upper_a), .input_change_lower_a(input_change_lower_a),
      .input_change_upper_b(input_change_upper_b), .input_change_lower_b(input_change_lower_b),
      .timer0_value(timer0_value), .timer1_value(timer1_value),
      .io_a_in(io_a_in), .io_b_in(io_b_in), .io_a_drive(io_a_drive), .io_b_drive(io_b_drive),
      .pin_function_select_a(pin_function_select_a),
      .pin_function_select_b(pin_function_select_b),
      .timer0_preset(timer0_preset), .timer1_preset(timer1_preset),
      .command_extension_a(command_extension_a), .command_extension_b(command_extension_b)
   );

   // ----------------------------------------------------------------
   // Clock, helpers and verdict
   // ----------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // Expected read data worked out from the values the bench drives
   function automatic logic [7:0] exp_read(input logic [6:0] a);
      case (a)
         7'h10: exp_read = rx_fill_count_a;
         7'h11: exp_read = tx_free_count_a;
         7'h12: exp_read = enhanced_status_word;
         7'h13: exp_read = input_change_upper_a;
         7'h14: exp_read = input_change_lower_a;
         7'h15: exp_read = io_a_in;
         7'h16: exp_read = timer0_value[15:8];
         7'h17: exp_read = timer0_value[7:0];
         7'h1b: exp_read = input_change_upper_b;
         7'h1c: exp_read = input_change_lower_b;
         7'h1d: exp_read = io_b_in;
         7'h1e: exp_read = timer1_value[15:8];
         7'h1f: exp_read = timer1_value[7:0];
         default: exp_read = 8'h00;
      endcase
   endfunction : exp_read

   // Pins follow a latch or select write one edge later; two edges leave margin
   task automatic settle;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask : settle

   task automatic test_end(input string name);
      $display("test %s done, mismatches so far %0d", name, fails);
   endtask : test_end

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      #200000;
      fails++;
      $display("ERROR %0t watchdog expired", $time);
      report_and_stop();
   end

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      rst_b = 1'b0;
      rx_fill_count_a = 8'h11;
      tx_free_count_a = 8'h22;
      enhanced_status_word = 8'h33;
      input_change_upper_a = 8'h44;
      input_change_lower_a = 8'h55;
      io_a_in = 8'h66;
      timer0_value = 16'h7788;
      input_change_upper_b = 8'h99;
      input_change_lower_b = 8'haa;
      io_b_in = 8'hbb;
      timer1_value = 16'hccdd;
      repeat (16) @(posedge sys_clk);
      #1;
      `CHK(io_a_drive, 16'hff00)
      `CHK(io_b_drive, 16'hff00)
      `CHK({pin_function_select_a, pin_function_select_b}, 32'h0)
      `CHK({timer0_preset, timer1_preset}, 32'h0)
      `CHK({command_extension_a, command_extension_b}, 18'h0)
      @(posedge sys_clk);
      rst_b <= 1'b1;
      test_end("reset");

      // All pins of both ports to latch output, then set and clear bits
      host_u.write_reg(7'h13, 8'h55);
      host_u.write_reg(7'h14, 8'h55);
      host_u.write_reg(7'h10, 8'h05);
      settle();
      `CHK(io_a_drive, 16'hfaff)
      `CHK(io_b_drive, 16'hff00)
      host_u.write_reg(7'h10, 8'h80);
      host_u.write_reg(7'h11, 8'h04);
      settle();
      `CHK(io_a_drive.level, 8'h7e)
      host_u.write_reg(7'h1b, 8'h55);
      host_u.write_reg(7'h1c, 8'h55);
      host_u.write_reg(7'h18, 8'hff);
      host_u.write_reg(7'h19, 8'h0f);
      settle();
      `CHK(io_b_drive, 16'h0fff)
      `CHK(io_a_drive.level, 8'h7e)
      `CHK({pin_function_select_a, pin_function_select_b}, 32'h55555555)
      test_end("latch");

      // Ignored writes leave latches, selects and presets alone
      host_u.write_reg(7'h15, 8'hff);
      host_u.write_reg(7'h1d, 8'hff);
      host_u.write_reg(7'h20, 8'hff);
      host_u.write_reg(7'h7f, 8'h00);
      settle();
      `CHK({io_a_drive.level, io_b_drive.level}, 16'h7e0f)
      `CHK({pin_function_select_a, pin_function_select_b}, 32'h55555555)
      `CHK({timer0_preset, timer1_preset}, 32'h0)
      test_end("ignored_writes");

      // Every function code once: pins 0..3 get codes 00, 11, 01, 10
      host_u.write_reg(7'h13, 8'h9c);
      host_u.write_reg(7'h14, 8'h00);
      settle();
      `CHK(io_a_drive, 16'h7e04)
      `CHK(pin_function_select_a, 16'h009c)
      test_end("select_codes");

      // Read map, with the latches set so a read-back would show up
      @(posedge sys_clk);
      io_a_in <= 8'h3c;
      for (int i = 0; i < 18; i++) begin
         rd_addr = (i == 17) ? 7'h7f : 7'h10 + 7'(i);
         host_u.read_reg(rd_addr, rd_val);
         `CHK(rd_val, exp_read(rd_addr))
      end
      test_end("read_map");

      // Command extension strobes and presets
      host_u.write_reg(7'h12, 8'ha5);
      #1;
      `CHK(command_extension_a, 9'h14b)
      `CHK(command_extension_b.stb, 1'b0)
      host_u.write_reg(7'h1a, 8'h3c);
      #1;
      `CHK(command_extension_b, 9'h079)
      `CHK(command_extension_a, 9'h14a)
      host_u.write_reg(7'h16, 8'h12);
      host_u.write_reg(7'h17, 8'h34);
      host_u.write_reg(7'h1f, 8'h78);
      host_u.write_reg(7'h1e, 8'h56);
      settle();
      `CHK({timer0_preset, timer1_preset}, 32'h12345678)
      `CHK({io_a_drive.level, io_b_drive.level}, 16'h7e0f)
      test_end("commands_presets");

      // Reset in mid-run clears latches and selects again
      @(posedge sys_clk);
      rst_b <= 1'b0;
      settle();
      `CHK(io_a_drive, 16'hff00)
      `CHK(io_b_drive, 16'hff00)
      @(posedge sys_clk);
      rst_b <= 1'b1;
      host_u.write_reg(7'h1c, 8'h01);
      settle();
      `CHK(io_b_drive, 16'hff10)
      test_end("second_reset");
      report_and_stop();
   end
endmodule : output_port_latch_and_low_decode_tb

// >>> pin_driver.sv
// Drives eight port pins from an output latch and a 16-bit select field.
// Assumes pin levels are resolved outside from level and output enable.
`timescale 1ns/1ns
module pin_driver
   import opl_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [7:0] latch,
   input wire logic [15:0] select,
   output pin_drive_s pins
);

   // ----------------------------------------------------------------
   // Per-pin drive
   // ----------------------------------------------------------------
   genvar n;
   generate
      for (n = 0; n < 8; n++) begin : g_pin
         always_ff @(posedge sys_clk) begin
            if (!rst_b) begin
               pins.level[n] <= 1'b1;
               pins.oe[n] <= 1'b0;
            end else begin
               // Driver is off for every other code; those functions live elsewhere
               pins.oe[n] <= (select[FUNC_CODE_W*n +: FUNC_CODE_W] == FUNC_LATCH_OUT);
               pins.level[n] <= ~latch[n];
            end
         end
      end
   endgenerate

endmodule : pin_driver

// >>> port_latch.sv
// One 8-bit output latch, changed only by bit-set and bit-clear strobes.
// Assumes set and clear never arrive together (they sit at different addresses).
`timescale 1ns/1ns
module port_latch
   import opl_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic set_stb,
   input wire logic clr_stb,
   input wire logic [7:0] mask,
   output logic [7:0] latch
);

   // ----------------------------------------------------------------
   // Latch bits
   // ----------------------------------------------------------------
   // No whole-byte load path exists, so software needs no shadow copy
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         latch <= LATCH_RESET;
      end else if (set_stb) begin
         latch <= latch | mask;
      end else if (clr_stb) begin
         latch <= latch & ~mask;
      end
   end

endmodule : port_latch
